/* File: hdl/ccsc_params.svh */
// Constants of the system-bus control block
`ifndef CCSC_PARAMS_SVH
`define CCSC_PARAMS_SVH
// Bus-cycle phases: each bus cycle spans four pclk cycles
`define CCSC_PH_C1R 2'h0
`define CCSC_PH_C1F 2'h1
`define CCSC_PH_C2R 2'h2
`define CCSC_PH_C2F 2'h3
// Processor request codes
`define CCSC_REQ_IDLE 3'h0
`define CCSC_REQ_WRBLK 3'h5
`define CCSC_REQ_LDLOCK 3'h6
`define CCSC_REQ_STCOND 3'h7
// Read data acknowledge codes
`define CCSC_RACK_IDLE 3'h0
`define CCSC_RACK_NC_NCHK 3'h4
`define CCSC_RACK_NC_CHK 3'h5
// Cycle acknowledge codes
`define CCSC_CACK_IDLE 3'h0
`define CCSC_CACK_HARD 3'h1
`define CCSC_CACK_SOFT 3'h2
`define CCSC_CACK_SCFAIL 3'h3
`define CCSC_CACK_OK 3'h4
// Bridge command codes while the processor owns the bus
`define CCSC_CMD_RACK_NC_NCHK 3'h2
`define CCSC_CMD_RACK_NC_CHK 3'h3
// Bridge bus request codes
`define CCSC_BREQ_IDLE 2'h0
`define CCSC_BREQ_PREEMPT 2'h1
`define CCSC_BREQ_DMA 2'h2
`define CCSC_BREQ_ATOMIC 2'h3
// Register map
`define CCSC_OFS_CTRL 12'h000
`define CCSC_OFS_STATUS 12'h004
`define CCSC_CTRL_RESET 2'h0
`define CCSC_CTRL_LONG_WRITE 0
`define CCSC_CTRL_STALL_IO 1
`endif

/* File: hdl/ccsc_phase_gen.sv */
// Bus-cycle phase counter
`timescale 1ns/1ps
`include "ccsc_params.svh"
module ccsc_phase_gen
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Current phase
	output logic [1:0] phase
);
	logic [1:0] next_phase;

	always_comb
	begin
		next_phase = phase + 2'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			phase <= `CCSC_PH_C1R;
		else
			phase <= next_phase;
	end
endmodule

/* File: hdl/ccsc_phase_reg.sv */
// Output flop that changes only on its chosen phase
`timescale 1ns/1ps
module ccsc_phase_reg #(parameter int W = 1)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Load on the chosen phase
	input wire logic load,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] next_q;

	always_comb
	begin
		next_q = load ? d : q;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			q <= '0;
		else
			q <= next_q;
	end
endmodule

/* File: hdl/ccsc_pkg.sv */
// Types of the system-bus control block
package ccsc_pkg;
	typedef enum logic [2:0] {ccsc_idle, ccsc_wait_end, ccsc_hold, ccsc_dma, ccsc_release} ccsc_state_t;
	// Events from the cache controller core
	typedef struct packed {
		logic fill;
		logic victim_read;
		logic wa_victim_next;
		logic read_hit;
		logic locked_hit;
		logic tag_write;
		logic data_write;
		logic noncacheable;
		logic upper_loaded;
		logic dma_active;
		logic invalidate;
		logic read_valid;
		logic read_cacheable;
		logic read_checked;
	} ccsc_core_ev_t;
	// Strobes to the cache glue logic
	typedef struct packed {
		logic early_oe_permit;
		logic tag_oe_permit;
		logic data_oe_permit;
		logic addr_low_phase_enable;
		logic addr_high_phase_enable;
		logic tag_write_enable;
		logic short_data_write_permit;
		logic long_data_write_enable;
		logic processor_drive_permit;
	} ccsc_glue_t;
endpackage

/* File: hdl/ccsc_sysbus_ctl.sv */
// System-bus control: acknowledges, cache hold handshake, glue strobes
`timescale 1ns/1ps
`include "ccsc_params.svh"
module ccsc_sysbus_ctl
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Processor
	input wire logic [2:0] processor_request_code,
	input wire logic cache_hold_acknowledge,
	input wire logic [33:5] system_address,
	output logic [2:0] read_data_acknowledge,
	output logic [2:0] cycle_acknowledge,
	output logic write_data_select,
	output logic dcache_invalidate_request,
	output logic [7:0] invalidate_index,
	output logic cache_hold_request,
	// Cache controller core events
	input wire ccsc_pkg::ccsc_core_ev_t core_ev,
	// Cache glue logic
	output ccsc_pkg::ccsc_glue_t glue,
	output logic tag_ram_oe_n,
	output logic data_ram_oe_n,
	output logic processor_data_oe_n,
	// Bridge
	input wire logic [1:0] bridge_bus_request,
	input wire logic [2:0] bridge_command,
	output logic bridge_bus_grant,
	// Bus phase
	output logic [1:0] phase
);
	import ccsc_pkg::*;

	ccsc_state_t state, next_state;
	logic [1:0] ctrl, next_ctrl;
	logic [31:0] next_prdata;
	logic [2:0] pend_cack, next_pend_cack;
	logic [2:0] fwd_rack, next_fwd_rack;
	logic wsel_seen, next_wsel_seen;
	logic next_wsel;
	logic inv_loaded, next_inv_loaded;
	logic dma_seen, next_dma_seen;
	logic ph_c1r, ph_c1f, ph_c2r, ph_c2f;
	logic cpu_owns, cpu_write, dma_first, stall_cack, addr_map_ok;
	logic tag_oe_d, tag_oe_ld, data_oe_d, data_oe_ld, toggle_d;
	logic [2:0] rack_d, cack_d;

	ccsc_phase_gen u_phase
	(
		.pclk(pclk),
		.presetn(presetn),
		.phase(phase)
	);

	assign ph_c1r = phase == `CCSC_PH_C1R;
	assign ph_c1f = phase == `CCSC_PH_C1F;
	assign ph_c2r = phase == `CCSC_PH_C2R;
	assign ph_c2f = phase == `CCSC_PH_C2F;
	assign cpu_owns = state == ccsc_idle || state == ccsc_wait_end;
	assign cpu_write = cpu_owns && (processor_request_code == `CCSC_REQ_WRBLK ||
		processor_request_code == `CCSC_REQ_STCOND);
	assign dma_first = state == ccsc_dma && core_ev.dma_active && !dma_seen;

	// APB slave: read data captured in setup, answer in the first access cycle
	assign addr_map_ok = paddr == `CCSC_OFS_CTRL || paddr == `CCSC_OFS_STATUS;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_map_ok;

	always_comb
	begin
		next_ctrl = ctrl;
		next_prdata = prdata;
		if (psel && penable && pwrite && paddr == `CCSC_OFS_CTRL)
			next_ctrl = pwdata[1:0];
		if (psel && !penable && !pwrite)
		begin
			next_prdata = 32'h0;
			if (paddr == `CCSC_OFS_CTRL)
				next_prdata[1:0] = ctrl;
			else if (paddr == `CCSC_OFS_STATUS)
				next_prdata[6:0] = {cache_hold_acknowledge, cache_hold_request,
					bridge_bus_grant, 1'b0, state};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl <= `CCSC_CTRL_RESET;
			prdata <= 32'h0;
		end
		else
		begin
			ctrl <= next_ctrl;
			prdata <= next_prdata;
		end
	end

	// Ownership arbitration, request sampled on clk1 falling
	always_comb
	begin
		next_state = state;
		if (ph_c1f)
		begin
			unique case (state)
				ccsc_idle:
					if (bridge_bus_request == `CCSC_BREQ_PREEMPT)
						next_state = ccsc_hold;
					else if (bridge_bus_request != `CCSC_BREQ_IDLE)
						next_state = (processor_request_code == `CCSC_REQ_IDLE) ?
							ccsc_hold : ccsc_wait_end;
				ccsc_wait_end:
					if (bridge_bus_request == `CCSC_BREQ_IDLE)
						next_state = ccsc_idle;
					else if (bridge_bus_request == `CCSC_BREQ_PREEMPT ||
						processor_request_code == `CCSC_REQ_IDLE)
						next_state = ccsc_hold;
				ccsc_hold:
					if (cache_hold_acknowledge)
						next_state = ccsc_dma;
				ccsc_dma:
					// Atomic code keeps ownership like any non-idle request
					if (bridge_bus_request == `CCSC_BREQ_IDLE && !core_ev.dma_active)
						next_state = ccsc_release;
				ccsc_release:
					if (!cache_hold_acknowledge)
						next_state = ccsc_idle;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ccsc_idle;
		else
			state <= next_state;
	end

	// Grant and hold change on clk1 rising
	ccsc_phase_reg #(.W(2)) u_grant
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1r),
		.d({state == ccsc_hold || state == ccsc_dma,
			state == ccsc_hold || state == ccsc_dma}),
		.q({bridge_bus_grant, cache_hold_request})
	);

	// Acknowledge forwarding, write select, invalidate and DMA tracking
	assign stall_cack = ctrl[`CCSC_CTRL_STALL_IO] && cpu_write && !write_data_select;

	always_comb
	begin
		next_pend_cack = pend_cack;
		next_fwd_rack = fwd_rack;
		next_wsel_seen = wsel_seen;
		next_inv_loaded = inv_loaded;
		next_dma_seen = dma_seen;
		if (ph_c1f && cpu_owns)
		begin
			next_fwd_rack = `CCSC_RACK_IDLE;
			if (bridge_command == `CCSC_CMD_RACK_NC_NCHK)
				next_fwd_rack = `CCSC_RACK_NC_NCHK;
			else if (bridge_command == `CCSC_CMD_RACK_NC_CHK)
				next_fwd_rack = `CCSC_RACK_NC_CHK;
			else if (bridge_command[2])
				next_pend_cack = (bridge_command[1:0] == 2'h0) ? `CCSC_CACK_OK :
					{1'b0, bridge_command[1:0]};
		end
		if (ph_c1r && !stall_cack)
			next_pend_cack = `CCSC_CACK_IDLE;
		next_wsel = write_data_select && !core_ev.upper_loaded;
		if (!cpu_write)
			{next_wsel_seen, next_wsel} = 2'h0;
		else if (!wsel_seen)
			{next_wsel_seen, next_wsel} = 2'h3;
		if (ph_c1r)
			next_inv_loaded = core_ev.invalidate && !inv_loaded;
		if (!core_ev.dma_active)
			next_dma_seen = 1'b0;
		else if (ph_c1r && state == ccsc_dma)
			next_dma_seen = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pend_cack <= `CCSC_CACK_IDLE;
			fwd_rack <= `CCSC_RACK_IDLE;
			wsel_seen <= 1'b0;
			write_data_select <= 1'b0;
			inv_loaded <= 1'b0;
			dma_seen <= 1'b0;
		end
		else
		begin
			pend_cack <= next_pend_cack;
			fwd_rack <= next_fwd_rack;
			wsel_seen <= next_wsel_seen;
			write_data_select <= next_wsel;
			inv_loaded <= next_inv_loaded;
			dma_seen <= next_dma_seen;
		end
	end

	assign rack_d = core_ev.read_valid ? {1'b1, core_ev.read_cacheable, core_ev.read_checked} :
		fwd_rack;
	assign cack_d = stall_cack ? `CCSC_CACK_IDLE : pend_cack;

	ccsc_phase_reg #(.W(6)) u_acks
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1r),
		.d({rack_d, cack_d}),
		.q({read_data_acknowledge, cycle_acknowledge})
	);

	// Index loads one bus cycle ahead of the request and stays until it ends
	ccsc_phase_reg #(.W(8)) u_inv_idx
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1r && core_ev.invalidate && !inv_loaded && !dcache_invalidate_request),
		.d(system_address[12:5]),
		.q(invalidate_index)
	);

	ccsc_phase_reg u_inv_req
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1r),
		.d(inv_loaded),
		.q(dcache_invalidate_request)
	);

	// Glue strobes
	assign tag_oe_d = (state == ccsc_dma && cache_hold_acknowledge) ||
		(cpu_owns && core_ev.noncacheable);
	assign tag_oe_ld = dma_first ? ph_c1r : ph_c1f;
	assign data_oe_d = core_ev.victim_read || core_ev.wa_victim_next ||
		core_ev.locked_hit || (state == ccsc_dma && core_ev.dma_active);
	assign data_oe_ld = dma_first ? ph_c1r : (core_ev.wa_victim_next ? ph_c1f : ph_c2f);
	assign toggle_d = core_ev.fill || core_ev.victim_read || core_ev.read_hit ||
		core_ev.locked_hit;

	ccsc_phase_reg u_early
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1r),
		.d(state == ccsc_idle && processor_request_code == `CCSC_REQ_IDLE),
		.q(glue.early_oe_permit)
	);

	ccsc_phase_reg u_tag_oe
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(tag_oe_ld),
		.d(tag_oe_d),
		.q(glue.tag_oe_permit)
	);

	ccsc_phase_reg u_data_oe
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(data_oe_ld),
		.d(data_oe_d),
		.q(glue.data_oe_permit)
	);

	ccsc_phase_reg u_addr_lo
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c2r),
		.d(toggle_d),
		.q(glue.addr_low_phase_enable)
	);

	ccsc_phase_reg u_addr_hi
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c2f),
		.d(toggle_d),
		.q(glue.addr_high_phase_enable)
	);

	ccsc_phase_reg #(.W(3)) u_c1r_strobes
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1r),
		.d({core_ev.tag_write,
			core_ev.data_write && !ctrl[`CCSC_CTRL_LONG_WRITE],
			cpu_write}),
		.q({glue.tag_write_enable, glue.short_data_write_permit, glue.processor_drive_permit})
	);

	ccsc_phase_reg u_long_we
	(
		.pclk(pclk),
		.presetn(presetn),
		.load(ph_c1f),
		.d(core_ev.data_write && ctrl[`CCSC_CTRL_LONG_WRITE]),
		.q(glue.long_data_write_enable)
	);

	// Output enables decoded from the request while the early permit stands
	always_comb
	begin
		tag_ram_oe_n = 1'b1;
		data_ram_oe_n = 1'b1;
		processor_data_oe_n = 1'b1;
		if (glue.early_oe_permit && processor_request_code != `CCSC_REQ_IDLE)
		begin
			tag_ram_oe_n = 1'b0;
			if (processor_request_code == `CCSC_REQ_WRBLK ||
				processor_request_code == `CCSC_REQ_STCOND)
				processor_data_oe_n = 1'b0;
			else
				data_ram_oe_n = 1'b0;
		end
	end

	a_rack_legal: assert property (@(posedge pclk) disable iff (!presetn)
		read_data_acknowledge == `CCSC_RACK_IDLE || read_data_acknowledge[2])
		else $error("illegal read acknowledge code");
	a_wsel_clear: assert property (@(posedge pclk) disable iff (!presetn)
		core_ev.upper_loaded |=> !write_data_select)
		else $error("write select stayed after upper load");
	a_inv_stable: assert property (@(posedge pclk) disable iff (!presetn)
		dcache_invalidate_request |-> $stable(invalidate_index))
		else $error("invalidate index moved during request");
	a_hold_waits_end: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ccsc_wait_end && ph_c1f && processor_request_code != `CCSC_REQ_IDLE &&
		bridge_bus_request == `CCSC_BREQ_DMA) |=> state == ccsc_wait_end)
		else $error("hold taken before transaction end");
	a_hold_preempt: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ccsc_idle && ph_c1f && bridge_bus_request == `CCSC_BREQ_PREEMPT)
		|-> ##[1:4] (cache_hold_request && bridge_bus_grant))
		else $error("preempt did not raise hold");
	a_early_idle: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(glue.early_oe_permit) |-> ph_c1f && !bridge_bus_grant)
		else $error("early permit outside idle cycle");
	a_tag_oe_edge: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(glue.tag_oe_permit) |-> (ph_c1f || ph_c2r))
		else $error("tag permit changed on wrong phase");
	a_data_oe_edge: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(glue.data_oe_permit) |-> !ph_c2f)
		else $error("data permit changed on wrong phase");
	a_tag_we_edge: assert property (@(posedge pclk) disable iff (!presetn)
		$changed(glue.tag_write_enable) |-> ph_c1f)
		else $error("tag write enable off its edge");
	a_write_mode: assert property (@(posedge pclk) disable iff (!presetn)
		!(glue.short_data_write_permit && glue.long_data_write_enable))
		else $error("short and long write both active");
	a_hold_kept: assert property (@(posedge pclk) disable iff (!presetn)
		(state == ccsc_dma && core_ev.dma_active) |=> ##3 cache_hold_request)
		else $error("hold dropped during DMA");
endmodule

/* File: verification/ccsc_proc_model.sv */
// Processor model answering the cache hold handshake
`timescale 1ns/1ps
module ccsc_proc_model
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Bus phase and answer speed
	input wire logic [1:0] phase,
	input wire logic slow,
	// Hold handshake
	input wire logic cache_hold_request,
	output logic cache_hold_acknowledge
);
	logic [2:0] held;
	// Bus cycles counted at the last phase while the request stands
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			held <= 3'h0;
			cache_hold_acknowledge <= 1'b0;
		end
		else if (phase == 2'h3)
		begin
			if (!cache_hold_request)
			begin
				held <= 3'h0;
				cache_hold_acknowledge <= 1'b0;
			end
			else if (held >= (slow ? 3'h4 : 3'h2))
				cache_hold_acknowledge <= 1'b1;
			else
				held <= held + 3'h1;
		end
	end
endmodule

/* File: verification/ccsc_sysbus_ctl_test.sv */
// Self-checking bench for the system-bus control block
`timescale 1ns/1ps
`include "ccsc_params.svh"
module ccsc_sysbus_ctl_test;
	import ccsc_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic [31:0] rd;
	logic pready, pslverr, err, ack, wds, inv_req, hold, grant, tag_n, data_n, proc_n;
	logic slow = 1'b0;
	logic [2:0] req_code = 3'h0;
	logic [2:0] bcmd = 3'h0;
	logic [2:0] rack, cack;
	logic [7:0] inv_idx;
	logic [33:5] sys_addr = 29'h0;
	logic [1:0] breq = 2'h0;
	logic [1:0] phase;
	ccsc_core_ev_t ev = '0;
	ccsc_glue_t glue;
	int error_cnt = 0;
	int total_checks = 0;

	ccsc_sysbus_ctl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .processor_request_code(req_code), .cache_hold_acknowledge(ack),
		.system_address(sys_addr), .read_data_acknowledge(rack), .cycle_acknowledge(cack),
		.write_data_select(wds), .dcache_invalidate_request(inv_req),
		.invalidate_index(inv_idx), .cache_hold_request(hold), .core_ev(ev), .glue(glue),
		.tag_ram_oe_n(tag_n), .data_ram_oe_n(data_n), .processor_data_oe_n(proc_n),
		.bridge_bus_request(breq), .bridge_command(bcmd), .bridge_bus_grant(grant),
		.phase(phase));
	ccsc_proc_model i_proc (.pclk(pclk), .presetn(presetn), .phase(phase), .slow(slow),
		.cache_hold_request(hold), .cache_hold_acknowledge(ack));

	initial
	begin
		forever
			#2.5 pclk = ~pclk;
	end

	task check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask

	task check_bit(input string name, input logic exp, input logic got);
		check_val(name, 32'(exp), 32'(got));
	endtask

	task complete_run();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Returns at the edge that loads clk1-rising outputs
	task edge0();
		do
		begin
			@(posedge pclk);
			#1;
		end
		while (phase !== 2'h0);
		@(posedge pclk);
	endtask

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task t_regs();
		apb(1'b0, `CCSC_OFS_CTRL, 32'h0);
		check_val("ctrl reset", 32'h0, rd);
		apb(1'b1, `CCSC_OFS_CTRL, 32'h3);
		apb(1'b0, `CCSC_OFS_CTRL, 32'h0);
		check_val("ctrl", 32'h3, rd);
		apb(1'b1, `CCSC_OFS_STATUS, 32'hff);
		apb(1'b0, `CCSC_OFS_STATUS, 32'h0);
		check_val("status", 32'h0, rd);
		apb(1'b0, 12'h010, 32'h0);
		check_bit("unmapped err", 1'b1, err);
		check_val("unmapped data", 32'h0, rd);
		apb(1'b1, `CCSC_OFS_CTRL, 32'h0);
		$display("test registers done");
	endtask

	task t_ack();
		for (int i = 2; i < 12; i++)
		begin
			edge0();
			bcmd <= (i < 8) ? 3'(i) : 3'h0;
			ev.read_valid <= (i >= 8);
			ev.read_cacheable <= i[1];
			ev.read_checked <= i[0];
			repeat (4) @(posedge pclk);
			bcmd <= 3'h0;
			ev.read_valid <= 1'b0;
			#1;
			if (i < 4)
				check_val("read ack", {29'h0, 2'b10, i[0]}, 32'(rack));
			else if (i < 8)
				check_val("cycle ack", (i == 4) ? 32'h4 : 32'(i - 4), 32'(cack));
			else
				check_val("read ack", {29'h0, 1'b1, i[1:0]}, 32'(rack));
		end
		repeat (4) @(posedge pclk);
		#1;
		check_val("read ack idle", 32'h0, 32'(rack));
		$display("test acknowledges done");
	endtask

	task t_inv();
		edge0();
		sys_addr <= {21'h1abcd, 8'ha5};
		ev.invalidate <= 1'b1;
		repeat (4) @(posedge pclk);
		ev.invalidate <= 1'b0;
		sys_addr <= {21'h0, 8'h3c};
		repeat (4) @(posedge pclk);
		#1;
		check_bit("invalidate", 1'b1, inv_req);
		check_val("index", 32'ha5, 32'(inv_idx));
		repeat (4) @(posedge pclk);
		#1;
		check_bit("invalidate end", 1'b0, inv_req);
		$display("test invalidate done");
	endtask

	task t_strobes();
		for (int c = 0; c < 10; c++)
		begin
			edge0();
			req_code <= 3'(c);
			ev.tag_write <= (c == 8);
			ev.data_write <= (c >= 8);
			#1;
			if (c < 8)
			begin
				check_bit("early permit", 1'b1, glue.early_oe_permit);
				check_bit("tag oe", c == 0, tag_n);
				check_bit("data oe", c == 0 || c == 5 || c == 7, data_n);
				check_bit("cpu oe", c != 5 && c != 7, proc_n);
			end
			repeat (2) @(posedge pclk);
			#1;
			if (c == 5 || c == 7)
				check_bit("write select", 1'b1, wds);
			@(posedge pclk) ev.upper_loaded <= 1'b1;
			@(posedge pclk) ev.upper_loaded <= 1'b0;
			#1;
			check_bit("select drop", 1'b0, wds);
			if (c >= 8)
			begin
				check_bit("short write", c == 8, glue.short_data_write_permit);
				check_bit("long write", c == 9, glue.long_data_write_enable);
			end
			if (c == 8)
				check_bit("tag write", 1'b1, glue.tag_write_enable);
			check_bit("drive permit", c == 5 || c == 7, glue.processor_drive_permit);
			@(posedge pclk);
			#1;
			check_bit("select stays low", 1'b0, wds);
			@(posedge pclk);
			ev.tag_write <= 1'b0;
			ev.data_write <= 1'b0;
			req_code <= 3'h0;
			if (c == 8)
				apb(1'b1, `CCSC_OFS_CTRL, 32'h1);
			repeat (8) @(posedge pclk);
		end
		apb(1'b1, `CCSC_OFS_CTRL, 32'h0);
		$display("test strobes done");
	endtask

	task t_glue();
		edge0();
		ev.fill <= 1'b1;
		ev.noncacheable <= 1'b1;
		repeat (3) @(posedge pclk);
		#1;
		check_bit("tag oe uncached", 1'b1, glue.tag_oe_permit);
		check_bit("addr low fill", 1'b1, glue.addr_low_phase_enable);
		check_bit("addr high fill", 1'b1, glue.addr_high_phase_enable);
		check_bit("data oe fill", 1'b0, glue.data_oe_permit);
		@(posedge pclk);
		ev.fill <= 1'b0;
		ev.noncacheable <= 1'b0;
		ev.wa_victim_next <= 1'b1;
		@(posedge pclk);
		#1;
		check_bit("data oe victim", 1'b1, glue.data_oe_permit);
		repeat (2) @(posedge pclk);
		#1;
		check_bit("tag oe cached", 1'b0, glue.tag_oe_permit);
		check_bit("addr low idle", 1'b0, glue.addr_low_phase_enable);
		check_bit("addr high idle", 1'b0, glue.addr_high_phase_enable);
		@(posedge pclk) ev.wa_victim_next <= 1'b0;
		repeat (4) @(posedge pclk);
		#1;
		check_bit("data oe end", 1'b0, glue.data_oe_permit);
		$display("test glue done");
	endtask

	task t_stall();
		apb(1'b1, `CCSC_OFS_CTRL, 32'h2);
		edge0();
		req_code <= `CCSC_REQ_WRBLK;
		repeat (2) @(posedge pclk);
		ev.upper_loaded <= 1'b1;
		@(posedge pclk) ev.upper_loaded <= 1'b0;
		edge0();
		bcmd <= 3'h4;
		repeat (4) @(posedge pclk);
		bcmd <= 3'h0;
		#1;
		check_val("cycle ack stalled", 32'h0, 32'(cack));
		@(posedge pclk) req_code <= `CCSC_REQ_IDLE;
		repeat (3) @(posedge pclk);
		#1;
		check_val("cycle ack released", 32'h4, 32'(cack));
		apb(1'b1, `CCSC_OFS_CTRL, 32'h0);
		$display("test stall done");
	endtask

	task t_own(input logic [1:0] code, input logic [2:0] proc, input logic s);
		int n;
		n = 0;
		@(posedge pclk);
		req_code <= proc;
		slow <= s;
		edge0();
		breq <= code;
		repeat (4) @(posedge pclk);
		#1;
		check_bit("grant", proc == 3'h0 || code == 2'h1, grant);
		check_bit("hold", proc == 3'h0 || code == 2'h1, hold);
		check_bit("tag oe before ack", 1'b0, glue.tag_oe_permit);
		@(posedge pclk) req_code <= 3'h0;
		repeat (8) @(posedge pclk);
		#1;
		check_bit("grant late", 1'b1, grant);
		@(posedge pclk);
		if (s)
			breq <= 2'h3;
		while (ack !== 1'b1 && n < 40)
		begin
			@(posedge pclk);
			#1;
			n++;
		end
		check_bit("hold ack", 1'b1, ack);
		@(posedge pclk) ev.dma_active <= 1'b1;
		breq <= 2'h0;
		repeat (4) @(posedge pclk);
		#1;
		check_bit("tag oe first", 1'b1, glue.tag_oe_permit);
		check_bit("data oe first", 1'b1, glue.data_oe_permit);
		repeat (4) @(posedge pclk);
		#1;
		check_bit("tag oe dma", 1'b1, glue.tag_oe_permit);
		check_bit("data oe dma", 1'b1, glue.data_oe_permit);
		check_bit("hold in dma", 1'b1, hold);
		@(posedge pclk) ev.dma_active <= 1'b0;
		repeat (8) @(posedge pclk);
		#1;
		check_bit("hold end", 1'b0, hold);
		check_bit("grant end", 1'b0, grant);
		repeat (8) @(posedge pclk);
		apb(1'b0, `CCSC_OFS_STATUS, 32'h0);
		check_val("status idle", 32'h0, rd);
		$display("test ownership %0d done", code);
	endtask

	initial
	begin
		repeat (11) @(posedge pclk);
		#1;
		check_bit("reset hold", 1'b0, hold);
		check_bit("reset tag oe", 1'b1, tag_n);
		check_bit("reset data oe", 1'b1, data_n);
		check_bit("reset cpu oe", 1'b1, proc_n);
		@(posedge pclk) presetn <= 1'b1;
		t_regs();
		t_ack();
		t_inv();
		t_strobes();
		t_glue();
		t_stall();
		t_own(2'h2, 3'h0, 1'b0);
		t_own(2'h2, 3'h4, 1'b1);
		t_own(2'h1, 3'h4, 1'b0);
		complete_run();
	end

	initial
	begin
		repeat (6000) @(posedge pclk);
		error_cnt++;
		$display("ERROR watchdog expected end seen hang");
		complete_run();
	end
endmodule
